// ### pkg/fsc_consts.svh
// Constants for the flash security gate and clock scaler.
`ifndef FSC_CONSTS_SVH
`define FSC_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register field positions
// ----------------------------------------------------------------------------
`define FSC_SCALER_LOADED_BIT 7
`define FSC_PRESCALE_BIT      6
`define FSC_RATIO_MSB         5
`define FSC_KEY_ACCESS_ENABLE_BIT        5
`define FSC_BACKDOOR_ENABLE_BIT         7
`define FSC_SEC_MSB           1
`define FSC_FPDIS_BIT         0

// ----------------------------------------------------------------------------
// Values
// ----------------------------------------------------------------------------
`define FSC_OPTION_RST        8'hFF
`define FSC_PROT_RST          8'hFF
`define FSC_SEC_OPEN          2'b10
`define FSC_SCALER_RST        8'h00
`define FSC_CONFIG_RST        8'h00
`define FSC_KEY_BYTES         8
`define FSC_PRESCALE_DIV      8

`endif

// ### pkg/fsc_pkg.sv
// Types shared by the flash security gate and clock scaler.
package fsc_pkg;

  typedef enum logic [1:0] {
    FSC_ACC_NONE  = 2'b00,
    FSC_ACC_CPU_S = 2'b01,
    FSC_ACC_CPU_U = 2'b10,
    FSC_ACC_BDC   = 2'b11
  } fsc_src_t;

  typedef enum logic [1:0] {
    FSC_KEY_IDLE  = 2'b00,
    FSC_KEY_ENTRY = 2'b01,
    FSC_KEY_FAIL  = 2'b10
  } fsc_key_state_t;

endpackage

// ### hdl/fsc_clk_div.sv
// Flash timing clock divider with optional divide-by-eight prescale.
`timescale 1ns/1ps
`include "fsc_consts.svh"
module fsc_clk_div #(
  parameter int RATIO_W = 6
) (
  input  wire logic               i_ref_clk,
  input  wire logic               i_rst,
  input  wire logic               i_run,
  input  wire logic               i_prescale,
  input  wire logic [RATIO_W-1:0] i_ratio,
  output logic                    o_tick
);

  logic [2:0]         pre_cnt_ff;
  logic [RATIO_W-1:0] div_cnt_ff;
  logic               pre_tick;
  logic               src_tick;

  // ----------------------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------------------
  assign pre_tick = (pre_cnt_ff == 3'h7);
  assign src_tick = i_prescale ? pre_tick : 1'b1;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      pre_cnt_ff <= 3'h0;
    end else if (!i_run) begin
      pre_cnt_ff <= 3'h0;
    end else begin
      pre_cnt_ff <= pre_cnt_ff + 3'h1;
    end
  end

  // ----------------------------------------------------------------------------
  // Ratio divider: one tick every ratio plus one selected input cycles.
  // ----------------------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      div_cnt_ff <= '0;
      o_tick     <= 1'b0;
    end else if (!i_run) begin
      div_cnt_ff <= '0;
      o_tick     <= 1'b0;
    end else begin
      o_tick <= 1'b0;
      if (src_tick) begin
        if (div_cnt_ff == i_ratio) begin
          div_cnt_ff <= '0;
          o_tick     <= 1'b1;
        end else begin
          div_cnt_ff <= div_cnt_ff + RATIO_W'(1);
        end
      end
    end
  end

endmodule // fsc_clk_div

// ### hdl/fsc_pulse_timer.sv
// Counts whole flash clock pulses for one program or erase operation.
`timescale 1ns/1ps
module fsc_pulse_timer #(
  parameter int CNT_W = 16
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_rst,
  input  wire logic             i_start,
  input  wire logic [CNT_W-1:0] i_pulses,
  input  wire logic             i_tick,
  output logic                  o_busy,
  output logic                  o_done
);

  logic [CNT_W-1:0] left_ff;

  // Each step ends on a flash clock tick; the first step can be a partial cycle, so timing is a pulse count.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      left_ff <= '0;
      o_busy  <= 1'b0;
      o_done  <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (!o_busy && i_start && i_pulses != '0) begin
        left_ff <= i_pulses;
        o_busy  <= 1'b1;
      end else if (o_busy && i_tick) begin
        if (left_ff == {{(CNT_W-1){1'b0}}, 1'b1}) begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
        end
        left_ff <= left_ff - CNT_W'(1);
      end
    end
  end

endmodule // fsc_pulse_timer

// ### hdl/fsc_flash_sec.sv
// Flash security gate, backdoor key unlock and flash clock scaler.
//
// Contract
// - Secured: untrusted memory and config writes dropped, reads zero.
// - Code 1:0 unsecured, other three secured.
// - Reset reloads option byte into option register.
// - Secured: debug module enable refused.
// - Secured: background mode only by pin strap.
// - Backdoor enable 0 disables key unlock.
// - Key access on: key writes are comparisons.
// - Key match on clear: code becomes 1:0.
// - Key writes accepted only from secure code.
// - Protection register writable only by debug.
// - Blank flash check disengages security.
// - Loaded flag read-only, set by first write.
// - Scaler low bits write once after reset.
// - Program and erase disabled until loaded.
// - Prescale bit selects bus or bus/8.
// - Flash clock is input over ratio plus one.
// - Operations timed in whole flash clock pulses.
// - Key access enable is config bit 5.
// - Security code in option bits 1:0.
// - Backdoor enable is option bit 7.
`timescale 1ns/1ps
`include "fsc_consts.svh"
module fsc_flash_sec
  import fsc_pkg::*;
#(
  parameter int PULSE_W = 16
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_rst,
  // Nonvolatile contents presented by the array.
  input  wire logic [7:0]       i_nv_option_byte,
  input  wire logic [7:0]       i_nv_protection_byte,
  input  wire logic [63:0]      i_nv_backdoor_key,
  input  wire logic             i_debug_mode_pin,
  // Register access.
  input  wire logic             i_scaler_wr,
  input  wire logic             i_config_wr,
  input  wire logic             i_prot_wr,
  input  wire logic [7:0]       i_wdata,
  input  fsc_pkg::fsc_src_t     i_src,
  // Memory access to secure resources (flash or RAM).
  input  wire logic             i_mem_rd,
  input  wire logic             i_mem_wr,
  input  wire logic             i_key_loc,
  input  wire logic [2:0]       i_key_idx,
  input  wire logic [7:0]       i_mem_rdata,
  // Flash operations.
  input  wire logic             i_op_start,
  input  wire logic [PULSE_W-1:0] i_op_pulses,
  input  wire logic             i_blank_ok,
  input  wire logic             i_dbg_en_req,
  output logic [7:0]            o_flash_clock_scaler,
  output logic [7:0]            o_flash_option_reg,
  output logic [7:0]            o_flash_config_reg,
  output logic [7:0]            o_protection_reg,
  output logic                  o_secured,
  output logic [7:0]            o_mem_rdata,
  output logic                  o_mem_wr_ok,
  output logic                  o_cmd_start,
  output logic                  o_dbg_en,
  output logic                  o_bkgd_active,
  output logic                  o_op_busy,
  output logic                  o_op_done,
  output logic                  o_fclk_tick
);

  import fsc_pkg::*;

  // ----------------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------------
  logic [7:0]     scaler_ff;
  logic [7:0]     option_ff;
  logic [7:0]     config_ff;
  logic [7:0]     prot_ff;
  logic           load_pend_ff;
  logic           pin_meta_ff;
  logic           pin_sync_ff;
  logic           strap_done_ff;
  logic           key_ok_ff;
  logic [3:0]     key_cnt_ff;
  logic           key_last_ff;
  fsc_key_state_t key_st_ff;
  fsc_key_state_t nxt_key_st;
  logic           secured;
  logic           trusted;
  logic           key_wr;
  logic           key_access_enable;
  logic           tick;
  logic           busy;
  logic           done;
  logic [7:0]     key_byte;

  assign secured  = (option_ff[`FSC_SEC_MSB:0] != `FSC_SEC_OPEN);
  assign trusted  = !secured || (i_src == FSC_ACC_CPU_S);
  assign key_access_enable   = config_ff[`FSC_KEY_ACCESS_ENABLE_BIT];
  assign key_wr   = i_mem_wr && i_key_loc && key_access_enable && (i_src == FSC_ACC_CPU_S);
  assign key_byte = i_nv_backdoor_key[{i_key_idx, 3'b000} +: 8];

  // ----------------------------------------------------------------------------
  // Option and protection registers loaded from nonvolatile bytes
  // ----------------------------------------------------------------------------
  // Reset forces a constant; the first clocked cycle after release copies
  // the nonvolatile bytes, so a port value is never loaded asynchronously.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      load_pend_ff <= 1'b1;
    end else begin
      load_pend_ff <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      option_ff <= `FSC_OPTION_RST;
    end else if (load_pend_ff) begin
      option_ff <= i_nv_option_byte;
    end else if (key_st_ff == FSC_KEY_ENTRY && i_config_wr && !i_wdata[`FSC_KEY_ACCESS_ENABLE_BIT]
                 && key_ok_ff && key_cnt_ff == 4'(`FSC_KEY_BYTES)
                 && option_ff[`FSC_BACKDOOR_ENABLE_BIT]) begin
      option_ff[`FSC_SEC_MSB:0] <= `FSC_SEC_OPEN;
    end else if (i_blank_ok) begin
      option_ff[`FSC_SEC_MSB:0] <= `FSC_SEC_OPEN;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      prot_ff <= `FSC_PROT_RST;
    end else if (load_pend_ff) begin
      prot_ff <= i_nv_protection_byte;
    end else if (i_prot_wr && i_src == FSC_ACC_BDC) begin
      prot_ff <= i_wdata;
    end
  end

  // ----------------------------------------------------------------------------
  // Configuration register
  // ----------------------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      config_ff <= `FSC_CONFIG_RST;
    end else if (i_config_wr && trusted) begin
      config_ff <= {2'b00, i_wdata[`FSC_KEY_ACCESS_ENABLE_BIT], 5'b0_0000};
    end
  end

  // ----------------------------------------------------------------------------
  // Backdoor key comparison
  // ----------------------------------------------------------------------------
  always_comb begin
    nxt_key_st = key_st_ff;
    case (key_st_ff)
      FSC_KEY_IDLE: begin
        if (i_config_wr && trusted && i_wdata[`FSC_KEY_ACCESS_ENABLE_BIT]) begin
          nxt_key_st = FSC_KEY_ENTRY;
        end
      end
      FSC_KEY_ENTRY: begin
        if (i_config_wr && !i_wdata[`FSC_KEY_ACCESS_ENABLE_BIT]) begin
          nxt_key_st = FSC_KEY_IDLE;
        end else if (key_wr && (key_last_ff || key_byte != i_wdata
                     || {1'b0, i_key_idx} != key_cnt_ff)) begin
          nxt_key_st = FSC_KEY_FAIL;
        end
      end
      FSC_KEY_FAIL: begin
        if (i_config_wr && !i_wdata[`FSC_KEY_ACCESS_ENABLE_BIT]) begin
          nxt_key_st = FSC_KEY_IDLE;
        end
      end
      default: nxt_key_st = FSC_KEY_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      key_st_ff <= FSC_KEY_IDLE;
    end else begin
      key_st_ff <= nxt_key_st;
    end
  end

  // Adjacent key writes are not supported; back-to-back writes fail the entry.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      key_cnt_ff  <= 4'h0;
      key_ok_ff   <= 1'b0;
      key_last_ff <= 1'b0;
    end else begin
      key_last_ff <= key_wr;
      if (key_st_ff == FSC_KEY_IDLE) begin
        key_cnt_ff <= 4'h0;
        key_ok_ff  <= 1'b1;
      end else if (key_wr) begin
        key_cnt_ff <= key_cnt_ff + 4'h1;
        if (nxt_key_st == FSC_KEY_FAIL) begin
          key_ok_ff <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Clock scaler register
  // ----------------------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      scaler_ff <= `FSC_SCALER_RST;
    end else if (i_scaler_wr && !scaler_ff[`FSC_SCALER_LOADED_BIT]) begin
      scaler_ff <= {1'b1, i_wdata[`FSC_PRESCALE_BIT:0]};
    end
  end

  fsc_clk_div #(
    .RATIO_W (6)
  ) u_div (
    .i_ref_clk  (i_ref_clk),
    .i_rst      (i_rst),
    .i_run      (scaler_ff[`FSC_SCALER_LOADED_BIT]),
    .i_prescale (scaler_ff[`FSC_PRESCALE_BIT]),
    .i_ratio    (scaler_ff[`FSC_RATIO_MSB:0]),
    .o_tick     (tick)
  );

  fsc_pulse_timer #(
    .CNT_W (PULSE_W)
  ) u_timer (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_start   (i_op_start && scaler_ff[`FSC_SCALER_LOADED_BIT]),
    .i_pulses  (i_op_pulses),
    .i_tick    (tick),
    .o_busy    (busy),
    .o_done    (done)
  );

  // ----------------------------------------------------------------------------
  // Debug strap and registered outputs
  // ----------------------------------------------------------------------------
  // The synchroniser runs through reset, so the level held at release is settled when captured.
  always_ff @(posedge i_ref_clk) begin
    pin_meta_ff <= i_debug_mode_pin;
    pin_sync_ff <= pin_meta_ff;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      strap_done_ff <= 1'b0;
      o_bkgd_active <= 1'b0;
    end else begin
      if (!strap_done_ff && !load_pend_ff) begin
        strap_done_ff <= 1'b1;
        o_bkgd_active <= !pin_sync_ff;
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_flash_clock_scaler <= 8'h00;
      o_flash_option_reg   <= `FSC_OPTION_RST;
      o_flash_config_reg   <= 8'h00;
      o_protection_reg     <= `FSC_PROT_RST;
      o_secured            <= 1'b1;
      o_mem_rdata          <= 8'h00;
      o_mem_wr_ok          <= 1'b0;
      o_cmd_start          <= 1'b0;
      o_dbg_en             <= 1'b0;
      o_op_busy            <= 1'b0;
      o_op_done            <= 1'b0;
      o_fclk_tick          <= 1'b0;
    end else begin
      o_flash_clock_scaler <= scaler_ff;
      o_flash_option_reg   <= option_ff;
      o_flash_config_reg   <= config_ff;
      o_protection_reg     <= prot_ff;
      o_secured            <= secured;
      o_mem_rdata          <= (i_mem_rd && trusted) ? i_mem_rdata : 8'h00;
      o_mem_wr_ok          <= i_mem_wr && trusted && !key_wr;
      o_cmd_start          <= i_mem_wr && trusted && !(i_key_loc && key_access_enable)
                              && scaler_ff[`FSC_SCALER_LOADED_BIT];
      o_dbg_en             <= i_dbg_en_req && !secured;
      o_op_busy            <= busy;
      o_op_done            <= done;
      o_fclk_tick          <= tick;
    end
  end

endmodule // fsc_flash_sec

// ### sim/fsc_flash_sec_properties.sv
// Port-level assertions for the flash security gate.
`timescale 1ns/1ps
module fsc_flash_sec_properties
  import fsc_pkg::*;
(
  input wire logic        i_ref_clk,
  input wire logic        i_rst,
  input wire logic        i_mem_rd,
  input wire logic        i_mem_wr,
  input wire logic        i_key_loc,
  input wire logic        i_prot_wr,
  input wire logic        i_scaler_wr,
  input wire logic [7:0]  i_wdata,
  input fsc_pkg::fsc_src_t i_src,
  input wire logic [7:0]  o_flash_clock_scaler,
  input wire logic [7:0]  o_flash_option_reg,
  input wire logic [7:0]  o_flash_config_reg,
  input wire logic [7:0]  o_protection_reg,
  input wire logic        o_secured,
  input wire logic [7:0]  o_mem_rdata,
  input wire logic        o_mem_wr_ok,
  input wire logic        o_cmd_start,
  input wire logic        o_dbg_en,
  input wire logic        o_op_busy,
  input wire logic        o_fclk_tick
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  property p_rd_zero;
    // One cycle on, the flag shows the state the gate used for this access.
    i_mem_rd && i_src != FSC_ACC_CPU_S |=> !o_secured || o_mem_rdata == 8'h00;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("blocked read leaked");
  property p_wr_block;
    i_mem_wr && i_src != FSC_ACC_CPU_S |=> !o_secured || !o_mem_wr_ok;
  endproperty
  a_wr_block: assert property (p_wr_block) else $error("blocked write taken");
  // Security and the option register are registered in the same cycle; the check still waits for a settled code.
  property p_sec_code;
    $stable(o_flash_option_reg) [*3] |-> o_secured == (o_flash_option_reg[1:0] != 2'b10);
  endproperty
  a_sec_code: assert property (p_sec_code) else $error("security state wrong");
  property p_dbg_lock;
    o_dbg_en |-> o_flash_option_reg[1:0] == 2'b10;
  endproperty
  a_dbg_lock: assert property (p_dbg_lock) else $error("debug on while secured");
  property p_scal_hold;
    o_flash_clock_scaler[7] |=> $stable(o_flash_clock_scaler);
  endproperty
  a_scal_hold: assert property (p_scal_hold) else $error("scaler rewritten");
  property p_scal_load;
    $rose(o_flash_clock_scaler[7]) |-> $past(i_scaler_wr, 2) && o_flash_clock_scaler[6:0] == $past(i_wdata[6:0], 2);
  endproperty
  a_scal_load: assert property (p_scal_load) else $error("scaler load wrong");
  property p_key_cmp;
    i_mem_wr && i_key_loc ##1 o_flash_config_reg[5] |-> !o_cmd_start;
  endproperty
  a_key_cmp: assert property (p_key_cmp) else $error("key write started command");
  property p_no_op;
    !o_flash_clock_scaler[7] |-> !o_op_busy && !o_fclk_tick;
  endproperty
  a_no_op: assert property (p_no_op) else $error("operation before load");
  property p_prot_bdc;
    i_prot_wr && i_src != FSC_ACC_BDC |-> ##2 $stable(o_protection_reg);
  endproperty
  a_prot_bdc: assert property (p_prot_bdc) else $error("protection changed by cpu");
  c_unlock: cover property ($fell(o_secured));
  c_block: cover property (o_secured && i_mem_rd && i_src == FSC_ACC_CPU_U);
  c_load: cover property ($rose(o_flash_clock_scaler[7]));
endmodule // fsc_flash_sec_properties

bind fsc_flash_sec fsc_flash_sec_properties i_fsc_flash_sec_properties (
  .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_mem_rd(i_mem_rd), .i_mem_wr(i_mem_wr), .i_key_loc(i_key_loc),
  .i_prot_wr(i_prot_wr), .i_scaler_wr(i_scaler_wr), .i_wdata(i_wdata), .i_src(i_src),
  .o_flash_clock_scaler(o_flash_clock_scaler), .o_flash_option_reg(o_flash_option_reg),
  .o_flash_config_reg(o_flash_config_reg), .o_protection_reg(o_protection_reg), .o_secured(o_secured),
  .o_mem_rdata(o_mem_rdata), .o_mem_wr_ok(o_mem_wr_ok), .o_cmd_start(o_cmd_start), .o_dbg_en(o_dbg_en),
  .o_op_busy(o_op_busy), .o_fclk_tick(o_fclk_tick));

// ### sim/fsc_bus_model.sv
// Behavioural CPU bus and debug controller facing the security gate.
`timescale 1ns/1ps
module fsc_bus_model
  import fsc_pkg::*;
(
  input  wire logic         i_ref_clk,
  output logic              o_scaler_wr,
  output logic              o_config_wr,
  output logic              o_prot_wr,
  output logic [7:0]        o_wdata,
  output fsc_pkg::fsc_src_t o_src,
  output logic              o_mem_rd,
  output logic              o_mem_wr,
  output logic              o_key_loc,
  output logic [2:0]        o_key_idx,
  output logic              o_op_start,
  output logic              o_blank_ok
);
  initial begin
    {o_scaler_wr, o_config_wr, o_prot_wr, o_mem_rd, o_mem_wr, o_key_loc, o_op_start, o_blank_ok} = 8'h00;
    o_wdata = 8'h00;
    o_key_idx = 3'h0;
    o_src = FSC_ACC_NONE;
  end
  // A released bus shows inverted data so stale values are never mistaken for live ones.
  task automatic rel;
    @(posedge i_ref_clk);
    {o_scaler_wr, o_config_wr, o_prot_wr, o_mem_rd, o_mem_wr, o_key_loc, o_op_start, o_blank_ok} <= 8'h00;
    o_src <= FSC_ACC_NONE;
    o_wdata <= ~o_wdata;
    o_key_idx <= ~o_key_idx;
  endtask
  task automatic wr(input int kind, input fsc_src_t src, input logic [7:0] d);
    @(posedge i_ref_clk);
    o_src <= src;
    o_wdata <= d;
    o_scaler_wr <= (kind == 0);
    o_config_wr <= (kind == 1);
    o_prot_wr <= (kind == 2);
    rel();
  endtask
  task automatic mem(input logic w, input fsc_src_t src, input logic key, input logic [2:0] idx, input logic [7:0] d);
    @(posedge i_ref_clk);
    o_src <= src;
    o_wdata <= d;
    o_mem_rd <= !w;
    o_mem_wr <= w;
    o_key_loc <= key;
    o_key_idx <= idx;
    rel();
  endtask
  task automatic pulse(input logic blank);
    @(posedge i_ref_clk);
    o_op_start <= !blank;
    o_blank_ok <= blank;
    rel();
  endtask
  // Each strobe is followed by an idle cycle, so key writes are never adjacent.
  task automatic enter_key(input fsc_src_t src, input logic [63:0] k);
    int b;
    wr(1, src, 8'h20);
    for (b = 0; b < 8; b++) mem(1'b1, src, 1'b1, 3'(b), k[8*b+:8]);
    wr(1, src, 8'h00);
  endtask
endmodule // fsc_bus_model

// ### sim/tb_top.sv
// Self-checking bench for the flash security gate and clock scaler.
`timescale 1ns/1ps
module tb_top;
  import fsc_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] nv_opt = 8'hff;
  logic [63:0] nv_key = '0;
  logic dbg_pin = 1'b1;
  logic dbg_req = 1'b0;
  logic [7:0] mem_data = 8'h00;
  logic scaler_wr, config_wr, prot_wr, mem_rd, mem_wr, key_loc, op_start, blank_ok;
  logic [7:0] wdata, scal, opt, cfg, prot, rdata;
  logic [2:0] key_idx;
  fsc_src_t src;
  logic secured, wr_ok, cmd, dbg_en, bkgd, busy, done, tick;
  int err_count = 0;
  int tests_run = 0;
  int wr_cnt = 0;
  int cmd_cnt = 0;
  int seed = 32'h0000_46aa;
  logic [7:0] scal_tab [4] = '{8'h00, 8'h05, 8'h49, 8'h7f};

  fsc_flash_sec i_fsc_flash_sec (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_nv_option_byte(nv_opt),
    .i_nv_protection_byte(8'hff), .i_nv_backdoor_key(nv_key), .i_debug_mode_pin(dbg_pin),
    .i_scaler_wr(scaler_wr), .i_config_wr(config_wr), .i_prot_wr(prot_wr), .i_wdata(wdata), .i_src(src),
    .i_mem_rd(mem_rd), .i_mem_wr(mem_wr), .i_key_loc(key_loc), .i_key_idx(key_idx), .i_mem_rdata(mem_data),
    .i_op_start(op_start), .i_op_pulses(16'h0003), .i_blank_ok(blank_ok), .i_dbg_en_req(dbg_req),
    .o_flash_clock_scaler(scal), .o_flash_option_reg(opt), .o_flash_config_reg(cfg),
    .o_protection_reg(prot), .o_secured(secured), .o_mem_rdata(rdata), .o_mem_wr_ok(wr_ok),
    .o_cmd_start(cmd), .o_dbg_en(dbg_en), .o_bkgd_active(bkgd), .o_op_busy(busy), .o_op_done(done),
    .o_fclk_tick(tick));
  fsc_bus_model i_fsc_bus_model (.i_ref_clk(i_ref_clk), .o_scaler_wr(scaler_wr), .o_config_wr(config_wr),
    .o_prot_wr(prot_wr), .o_wdata(wdata), .o_src(src), .o_mem_rd(mem_rd), .o_mem_wr(mem_wr),
    .o_key_loc(key_loc), .o_key_idx(key_idx), .o_op_start(op_start), .o_blank_ok(blank_ok));

  always #5 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) begin
    if (wr_ok === 1'b1) wr_cnt++;
    if (cmd === 1'b1) cmd_cnt++;
  end

  function automatic int period(input logic [7:0] s);
    return (s[6] ? 8 : 1) * (int'(s[5:0]) + 1);
  endfunction
  function automatic logic key_unlock(input logic [7:0] o, input fsc_src_t s, input logic [63:0] w, k);
    return o[7] && s == FSC_ACC_CPU_S && w === k;
  endfunction
  task automatic close_out;
    if (err_count == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  task automatic boot(input logic [7:0] o, input logic p);
    @(posedge i_ref_clk);
    i_rst <= 1'b1;
    nv_opt <= o;
    dbg_pin <= p;
    repeat (12) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    cyc(4);
  endtask
  task automatic wait_for(input bit on_done, output int n);
    for (n = 0; n < 2000 && (on_done ? done : tick) !== 1'b1; n++) cyc(1);
  endtask

  initial begin : main
    logic [63:0] k;
    logic [7:0] s;
    int c;
    int n;
    int m;
    for (c = 0; c < 4; c++) begin
      boot(8'h80 | 8'(c), c[0]);
      check(opt, 8'h80 | 8'(c));
      check(secured, c != 2);
      if (c != 2) check(bkgd, !c[0]);
    end
    @(posedge i_ref_clk);
    mem_data <= 8'($random(seed));
    for (c = 1; c < 4; c++) begin
      m = wr_cnt;
      i_fsc_bus_model.mem(1'b0, fsc_src_t'(c), 1'b0, 3'h0, 8'h00);
      #1;
      check(rdata, (c == 1) ? mem_data : 8'h00);
      i_fsc_bus_model.mem(1'b1, fsc_src_t'(c), 1'b0, 3'h0, 8'h5a);
      cyc(3);
      check(16'(wr_cnt - m), c == 1);
    end
    @(posedge i_ref_clk);
    dbg_req <= 1'b1;
    cyc(4);
    check(dbg_en, 1'b0);
    i_fsc_bus_model.wr(2, FSC_ACC_CPU_S, 8'hf8);
    cyc(3);
    check(prot, 8'hff);
    i_fsc_bus_model.wr(2, FSC_ACC_BDC, 8'hf8);
    cyc(3);
    check(prot, 8'hf8);
    for (c = 0; c < 4; c++) begin
      s = scal_tab[c];
      boot(8'h82, 1'b1);
      i_fsc_bus_model.pulse(1'b0);
      cyc(3);
      check(busy, 1'b0);
      i_fsc_bus_model.wr(0, FSC_ACC_CPU_U, s);
      cyc(3);
      check(scal, {1'b1, s[6:0]});
      i_fsc_bus_model.wr(0, FSC_ACC_CPU_S, 8'($random(seed)));
      cyc(3);
      check(scal, {1'b1, s[6:0]});
      wait_for(1'b0, n);
      m = 0;
      do begin
        cyc(1);
        m++;
      end while (tick !== 1'b1 && m < 2000);
      check(16'(m), 16'(period(s)));
      i_fsc_bus_model.pulse(1'b0);
      wait_for(1'b1, n);
      check(n >= 2 * period(s) && n <= 3 * period(s) + 3, 1'b1);
      if (n == 2000 || m == 2000) begin
        err_count++;
        close_out();
      end
    end
    for (c = 0; c < 4; c++) begin
      k = {32'($random(seed)), 32'($random(seed))};
      @(posedge i_ref_clk);
      nv_key <= k;
      boot(c == 2 ? 8'h03 : 8'h83, 1'b1);
      i_fsc_bus_model.wr(0, FSC_ACC_CPU_S, 8'h7f);
      m = cmd_cnt;
      s = (c == 1) ? ~k[15:8] : k[15:8];
      i_fsc_bus_model.enter_key(c == 3 ? FSC_ACC_BDC : FSC_ACC_CPU_S, {k[63:16], s, k[7:0]});
      cyc(3);
      if (c != 3) check(16'(cmd_cnt - m), 16'h0000);
      check(secured, !key_unlock(nv_opt, c == 3 ? FSC_ACC_BDC : FSC_ACC_CPU_S, {k[63:16], s, k[7:0]}, k));
      if (c == 0) begin
        i_fsc_bus_model.mem(1'b0, FSC_ACC_CPU_U, 1'b0, 3'h0, 8'h00);
        #1;
        check(rdata, mem_data);
        check(dbg_en, 1'b1);
      end
      if (c != 3) begin
        m = cmd_cnt;
        i_fsc_bus_model.mem(1'b1, FSC_ACC_CPU_S, 1'b1, 3'h0, 8'h11);
        cyc(3);
        check(16'(cmd_cnt - m), 16'h0001);
      end
    end
    boot(8'h83, 1'b1);
    check(secured, 1'b1);
    i_fsc_bus_model.pulse(1'b1);
    cyc(3);
    check(secured, 1'b0);
    close_out();
  end
endmodule // tb_top
